// File: rtl/adcscr_host.sv
`timescale 1ns/100ps
// Overview of operation
// - serial clock generated no faster than 50 MHz
// - host raises start line after config bits are clocked in
// - host holds data-in high except during a config load
// - chain of N devices needs 8 times N falling edges
// - without busy, wait max conversion time before readback
// - busy modes: data-out low signals conversion complete
// - keep clock and data quiet in early conversion phase
// - inputs quiet 25 ns before and 10 ns after start rise
// - data valid on both edges; host samples on falling edge
// - host idles serial clock low
// - read all old result bits before newer ones
module adcscr_host (
    // clock and reset
    input  wire logic        clk_sys_i,
    input  wire logic        rst_i,
    // user commands
    input  wire logic        cfg_req_i,
    input  wire logic [7:0]  cfg_byte_i,
    input  wire logic [2:0]  chain_len_m1_i,
    input  wire logic        conv_req_i,
    output logic             busy_o,
    output logic             result_valid_o,
    output logic [17:0]      result_o,
    output logic [1:0]       result_idx_o,
    // device pins
    output logic             convert_start_select_o,
    output logic             sclk_o,
    output logic             din_o,
    input  wire logic        dout_i
);
    // ------------------------------------------------------------------
    // input synchroniser
    // ------------------------------------------------------------------
    logic dout_s1_q, dout_s2_q;
    always_ff @(posedge clk_sys_i) begin
        dout_s1_q <= dout_i;
        dout_s2_q <= dout_s1_q;
    end

    // ------------------------------------------------------------------
    // controller
    // ------------------------------------------------------------------
    adcscr_pkg::adcscr_state_t st_q, st_d;
    localparam int CNT_W = adcscr_pkg::CNT_W;  // timer width for the compare casts
    logic [adcscr_pkg::CNT_W-1:0]     tmr_q, tmr_d;
    logic [adcscr_pkg::BIT_CNT_W-1:0] bit_q, bit_d, nbits;
    logic [7:0]  cfg_q, cfg_d, mode_cfg_q, mode_cfg_d;
    logic [17:0] sh_q, sh_d, res_q, res_d;
    logic [1:0]  idx_q, idx_d, chain_q, chain_d;
    logic        cs_q, cs_d, sclk_q, sclk_d, din_q, din_d, val_q, val_d;
    logic        busy_mode, chain_mode;

    assign busy_mode  = mode_cfg_q[adcscr_pkg::MODE_LSB];
    assign chain_mode = mode_cfg_q[adcscr_pkg::MODE_MSB];
    // busy modes need one extra edge for the flag bit
    assign nbits = busy_mode ?
                   7'(adcscr_pkg::RESULT_BITS + 1) : 7'(adcscr_pkg::RESULT_BITS);

    // next-state logic
    always_comb begin
        st_d = st_q;
        tmr_d = tmr_q;
        bit_d = bit_q;
        cfg_d = cfg_q;
        mode_cfg_d = mode_cfg_q;
        sh_d = sh_q;
        res_d = res_q;
        idx_d = idx_q;
        chain_d = chain_q;
        cs_d = cs_q;
        sclk_d = sclk_q;
        din_d = 1'b1;
        val_d = 1'b0;
        case (st_q)
            adcscr_pkg::ST_IDLE: begin
                sclk_d = 1'b0;
                cs_d = 1'b1;
                if (cfg_req_i) begin
                    // bits 2:0 forced to zero
                    cfg_d = {cfg_byte_i[7:3], 3'h0};
                    chain_d = chain_len_m1_i[1:0];
                    sclk_d = 1'b1;
                    tmr_d = '0;
                    st_d = adcscr_pkg::ST_CFG_HI;
                end else if (conv_req_i) begin
                    // start line low through the quiet time, its rise samples
                    cs_d = 1'b0;
                    tmr_d = '0;
                    st_d = adcscr_pkg::ST_QUIET;
                end
            end
            adcscr_pkg::ST_CFG_HI: begin
                // clock high, then drop start line to enter config write
                tmr_d = tmr_q + 1'b1;
                if (tmr_q == CNT_W'(adcscr_pkg::SCLK_HALF_CYC)) begin
                    cs_d = 1'b0;
                    tmr_d = '0;
                    bit_d = '0;
                    din_d = cfg_q[7];
                    st_d = adcscr_pkg::ST_CFG_FL;
                end
            end
            adcscr_pkg::ST_CFG_FL: begin
                din_d = cfg_q[7];
                tmr_d = tmr_q + 1'b1;
                if (tmr_q == CNT_W'(adcscr_pkg::SCLK_HALF_CYC)) begin
                    sclk_d = 1'b0;
                    tmr_d = '0;
                    st_d = adcscr_pkg::ST_CFG_SH;
                end
            end
            adcscr_pkg::ST_CFG_SH: begin
                din_d = cfg_q[7];
                tmr_d = tmr_q + 1'b1;
                if (tmr_q == CNT_W'(adcscr_pkg::SCLK_HALF_CYC)) begin
                    tmr_d = '0;
                    bit_d = bit_q + 1'b1;
                    // same byte sent to each device in the chain
                    cfg_d = {cfg_q[6:0], cfg_q[7]};
                    if (bit_q == 7'({chain_q, 3'h7})) begin
                        cs_d = 1'b1;
                        // takes effect from the next conversion
                        // one more rotation gives the byte as sent
                        mode_cfg_d = {cfg_q[6:0], cfg_q[7]};
                        // sent shutdown bit sits one place lower here
                        if (cfg_q[adcscr_pkg::PDOWN_POS - 1])
                            mode_cfg_d = 8'h00;
                        st_d = adcscr_pkg::ST_DONE;
                    end else begin
                        sclk_d = 1'b1;
                        st_d = adcscr_pkg::ST_CFG_FL;
                    end
                end
            end
            adcscr_pkg::ST_QUIET: begin
                // clock and data idle before the sampling edge
                tmr_d = tmr_q + 1'b1;
                if (tmr_q == CNT_W'(adcscr_pkg::QUIET_BEFORE_CYC)) begin
                    cs_d = 1'b1;
                    tmr_d = '0;
                    st_d = adcscr_pkg::ST_CONV;
                end
            end
            adcscr_pkg::ST_CONV: begin
                tmr_d = tmr_q + 1'b1;
                if (tmr_q == CNT_W'(adcscr_pkg::QUIET_AFTER_CYC)) begin
                    tmr_d = '0;
                    st_d = adcscr_pkg::ST_WAIT;
                    if (busy_mode)
                        cs_d = 1'b0;  // watch for the completion flag
                end
            end
            adcscr_pkg::ST_WAIT: begin
                tmr_d = tmr_q + 1'b1;
                // busy modes: data-out low flags completion
                if (busy_mode ? (!dout_s2_q && tmr_q > CNT_W'(adcscr_pkg::QUIET_AFTER_CYC))
                              : (tmr_q == CNT_W'(adcscr_pkg::CONV_MAX_CYC))) begin
                    cs_d = 1'b0;
                    tmr_d = '0;
                    bit_d = '0;
                    idx_d = '0;
                    st_d = adcscr_pkg::ST_RD_SEL;
                end
            end
            adcscr_pkg::ST_RD_SEL: begin
                tmr_d = tmr_q + 1'b1;
                if (tmr_q == CNT_W'(adcscr_pkg::SCLK_HALF_CYC)) begin
                    sclk_d = 1'b1;
                    tmr_d = '0;
                    st_d = adcscr_pkg::ST_RD_SH;
                end
            end
            adcscr_pkg::ST_RD_SH: begin
                tmr_d = tmr_q + 1'b1;
                if (tmr_q == CNT_W'(adcscr_pkg::SCLK_HALF_CYC)) begin
                    tmr_d = '0;
                    // sample just before the falling edge, MSB first
                    sh_d = {sh_q[16:0], dout_s2_q};
                    sclk_d = 1'b0;
                    st_d = adcscr_pkg::ST_RD_SEL;
                    if (bit_q == nbits - 7'h1) begin
                        // whole word read before the next conversion
                        res_d = {sh_q[16:0], dout_s2_q};
                        val_d = 1'b1;
                        bit_d = '0;
                        idx_d = idx_q + 1'b1;
                        // chain: keep clocking results through
                        if (!chain_mode || idx_q == chain_q) begin
                            cs_d = 1'b1;
                            st_d = adcscr_pkg::ST_DONE;
                        end
                    end else begin
                        bit_d = bit_q + 1'b1;
                    end
                end
            end
            adcscr_pkg::ST_DONE: begin
                // activity ends before the next sampling edge
                sclk_d = 1'b0;
                cs_d = 1'b1;
                st_d = adcscr_pkg::ST_IDLE;
            end
            default: begin
                st_d = adcscr_pkg::ST_IDLE;
            end
        endcase
    end

    // state registers
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            st_q <= adcscr_pkg::ST_IDLE;
            tmr_q <= '0;
            bit_q <= '0;
            cfg_q <= 8'h00;
            mode_cfg_q <= 8'h00;
            sh_q <= '0;
            res_q <= '0;
            idx_q <= '0;
            chain_q <= '0;
            cs_q <= 1'b1;
            sclk_q <= 1'b0;
            din_q <= 1'b1;
            val_q <= 1'b0;
        end else begin
            st_q <= st_d;
            tmr_q <= tmr_d;
            bit_q <= bit_d;
            cfg_q <= cfg_d;
            mode_cfg_q <= mode_cfg_d;
            sh_q <= sh_d;
            res_q <= res_d;
            idx_q <= idx_d;
            chain_q <= chain_d;
            cs_q <= cs_d;
            sclk_q <= sclk_d;
            din_q <= din_d;
            val_q <= val_d;
        end
    end

    // outputs
    assign busy_o = (st_q != adcscr_pkg::ST_IDLE);
    assign result_valid_o = val_q;
    assign result_o = res_q;
    assign result_idx_o = idx_q - 2'h1;
    assign convert_start_select_o = cs_q;
    assign sclk_o = sclk_q;
    assign din_o = din_q;
endmodule // adcscr_host

// File: rtl/adcscr_pkg.sv
package adcscr_pkg;
    // ------------------------------------------------------------------
    // configuration byte layout
    // ------------------------------------------------------------------
    localparam int CFG_BITS      = 8;
    localparam int MODE_MSB      = 7;
    localparam int MODE_LSB      = 6;
    localparam int REF_MSB       = 5;
    localparam int REF_LSB       = 4;
    localparam int PDOWN_POS     = 3;
    localparam int RESULT_BITS   = 18;
    localparam int MAX_CHAIN     = 4;

    // output modes
    localparam logic [1:0] MODE_SEL_NOBUSY = 2'h0;
    localparam logic [1:0] MODE_SEL_BUSY   = 2'h1;
    localparam logic [1:0] MODE_DC_NOBUSY  = 2'h2;
    localparam logic [1:0] MODE_DC_BUSY    = 2'h3;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_NS        = 10;
    localparam int SCLK_MAX_MHZ  = 50;
    localparam int SCLK_HALF_CYC = 2;   // 3 cycles per half, 6 cycles = 16.7 MHz, below the 50 MHz limit
    localparam int QUIET_BEFORE_NS = 25;
    localparam int QUIET_AFTER_NS  = 10;
    localparam int QUIET_BEFORE_CYC = (QUIET_BEFORE_NS + CLK_NS - 1) / CLK_NS;
    localparam int QUIET_AFTER_CYC  = (QUIET_AFTER_NS + CLK_NS - 1) / CLK_NS;
    localparam int CONV_MAX_NS   = 1600;
    localparam int CONV_MAX_CYC  = (CONV_MAX_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W         = 8;
    localparam int BIT_CNT_W     = 7;

    // controller states, gray from ST_IDLE to ST_CFG_SH and from ST_QUIET to ST_DONE
    typedef enum logic [3:0] {
        ST_IDLE   = 4'h0,
        ST_CFG_HI = 4'h1,
        ST_CFG_FL = 4'h3,
        ST_CFG_SH = 4'h2,
        ST_QUIET  = 4'h6,
        ST_CONV   = 4'h7,
        ST_WAIT   = 4'h5,
        ST_RD_SEL = 4'h4,
        ST_RD_SH  = 4'hc,
        ST_DONE   = 4'hd
    } adcscr_state_t;
endpackage

// File: testbench/adcscr_dev_model.sv
`timescale 1ns/100ps
module adcscr_dev_model #(
    parameter int CONV_NS = 1000
) (
    // host pins
    input  logic        cs_i,
    input  logic        sclk_i,
    input  logic        din_i,
    output logic        dout_o,
    // sample and register view
    input  logic [17:0] sample_i,
    output logic [7:0]  cfg_o,
    output logic [7:0]  act_o
);
    logic [7:0]  cfg_q = '0, act_q = '0;
    logic [18:0] sr_q = '0;
    logic        wr_q = 0, rdy_q = 0, out_q = 0, last_q = 0;
    int          n_q = 0;
    logic        conv_q = 0;
    time         done_t = 0;
    assign cfg_o = cfg_q;
    assign act_o = act_q;
    // released line: pull-up in busy modes, else inverse of the last bit
    assign dout_o = out_q ? sr_q[18] : (act_q[6] | ~last_q);
    // start falling: load entry with clock high, else no-busy readout
    always @(negedge cs_i) begin
        if (sclk_i === 1'b1) begin
            wr_q = 1;
            n_q  = 0;
        end else if (rdy_q && !act_q[6]) begin
            sr_q  = {sample_i, 1'b0};
            out_q = 1;
            rdy_q = 0;
            n_q   = 0;
        end
    end
    // falling clock: shift config in or result out
    always @(negedge sclk_i) begin
        if (wr_q && n_q < 8) begin
            cfg_q = {cfg_q[6:0], din_i};
            n_q++;
        end else if (out_q) begin
            last_q = sr_q[18];
            sr_q   = sr_q << 1;
            n_q++;
            if (n_q == (act_q[6] ? 19 : 18)) out_q = 0;
        end
    end
    // start rising: end a load, or start a conversion
    always @(posedge cs_i) begin
        if (wr_q) begin
            wr_q = 0;
            if (cfg_q[3]) cfg_q = '0;
        end else begin
            act_q  = cfg_q;
            out_q  = 0;
            rdy_q  = 0;
            conv_q = 1;
            done_t = $time + CONV_NS;
        end
    end
    // conversion runs on its own, start line edges stay visible meanwhile
    always #1 begin
        if (conv_q && $time >= done_t) begin
            conv_q = 0;
            rdy_q  = 1;
            if (act_q[6]) begin
                sr_q  = {1'b0, sample_i};
                n_q   = 0;
                out_q = 1;
            end
        end
    end
endmodule // adcscr_dev_model

// File: testbench/adcscr_host_monitor.sv
`timescale 1ns/100ps
module adcscr_chk (
    // clock and reset
    input logic       clk_sys_i,
    input logic       rst_i,
    // user side
    input logic       cfg_req_i,
    input logic [7:0] cfg_byte_i,
    input logic [2:0] chain_len_m1_i,
    input logic       busy_o,
    input logic       result_valid_o,
    // device pins
    input logic       convert_start_select_o,
    input logic       sclk_o,
    input logic       din_o,
    input logic       dout_i
);
    // --------
    // shadow of the host bookkeeping
    // --------
    logic       cfg_q, cfg_d, sck_q, sck_d;
    logic [1:0] mode_q, mode_d;
    logic [7:0] byte_q, byte_d;
    logic [5:0] nf_q, nf_d;
    logic [8:0] hi_q, hi_d;
    logic [3:0] lo_q, lo_d;
    logic       csp_q, csp_d, cv_q, cv_d;
    wire        take = !busy_o && cfg_req_i;
    wire        cs = convert_start_select_o;
    // next values: load kind, tracked mode, falling edges, start-high time
    always_comb begin
        cfg_d  = busy_o ? cfg_q : cfg_req_i;
        mode_d = take ? (cfg_byte_i[3] ? 2'h0 : cfg_byte_i[7:6]) : mode_q;
        byte_d = take ? cfg_byte_i : byte_q;
        nf_d   = take ? 6'h0 : nf_q + 6'(sck_q && !sclk_o);
        hi_d   = !cs ? 9'h0 : hi_q + 9'(hi_q != 9'h1ff); // saturates
        sck_d  = sclk_o;
        lo_d   = cs ? 4'h0 : lo_q + 4'(lo_q != 4'hf);
        csp_d  = cs;
        // conversion start: short low then rise; cleared at first readout clock
        cv_d   = (cs && !csp_q && !cfg_q && lo_q < 4'h8) ? 1'b1 : (sclk_o ? 1'b0 : cv_q);
    end
    // register the shadow
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            {cfg_q, mode_q, byte_q, nf_q, hi_q, sck_q} <= '0;
            {lo_q, csp_q, cv_q} <= '0;
        end else begin
            {cfg_q, mode_q, byte_q, nf_q, hi_q, sck_q} <= {cfg_d, mode_d, byte_d, nf_d, hi_d, sck_d};
            {lo_q, csp_q, cv_q} <= {lo_d, csp_d, cv_d};
        end
    end
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    sclk_high_a: assert property ($rose(sclk_o) |-> sclk_o[*2])
        else $error("serial clock high phase too short");
    din_idle_a: assert property (!cfg_q |-> din_o)
        else $error("data-in not high outside a load");
    cfg_entry_a: assert property ($fell(cs) && cfg_q |-> sclk_o)
        else $error("load entered with serial clock low");
    read_entry_a: assert property ($fell(cs) && !cfg_q |-> !sclk_o)
        else $error("readout select with serial clock high");
    cfg_msb_a: assert property ($fell(cs) && cfg_q |-> din_o == byte_q[7])
        else $error("first config bit is not bit 7");
    cfg_edges_a: assert property ($rose(cs) && cfg_q |-> nf_q == {chain_len_m1_i[1:0] + 3'h1, 3'h0})
        else $error("wrong number of falling edges in load");
    conv_wait_a: assert property ($fell(cs) && cv_q && !mode_q[0] |-> hi_q >= adcscr_pkg::CONV_MAX_CYC)
        else $error("readout before maximum conversion time");
    busy_flag_a: assert property ($rose(sclk_o) && cv_q && mode_q[0] |-> !dout_i)
        else $error("readout before completion flag");
    cover property ($rose(sclk_o) && cfg_q);
    cover property (result_valid_o && mode_q[0]);
    cover property ($fell(cs) && !cfg_q && !mode_q[0]);
endmodule // adcscr_chk
bind adcscr_host adcscr_chk i_chk (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .cfg_req_i(cfg_req_i),
    .cfg_byte_i(cfg_byte_i), .chain_len_m1_i(chain_len_m1_i), .busy_o(busy_o),
    .result_valid_o(result_valid_o), .convert_start_select_o(convert_start_select_o),
    .sclk_o(sclk_o), .din_o(din_o), .dout_i(dout_i));

// File: testbench/tb.sv
`timescale 1ns/100ps
module tb;
    logic        clk_sys_i = 0, rst_i = 1, cfg_req_i = 0, conv_req_i = 0;
    logic        busy_o, result_valid_o, cs, sclk, din, dout;
    logic [7:0]  cfg_byte_i = '0, dev_cfg, dev_act, exp_act = '0;
    logic [17:0] res_v = '0, result_o;
    logic [1:0]  result_idx_o;
    logic [31:0] seed = 32'hcf115b9b;
    logic [17:0] exp_q[$];
    int          n_fail = 0, comparisons = 0;
    initial forever #5 clk_sys_i = ~clk_sys_i;
    adcscr_host i_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .cfg_req_i(cfg_req_i),
        .cfg_byte_i(cfg_byte_i), .chain_len_m1_i(3'h0), .conv_req_i(conv_req_i),
        .busy_o(busy_o), .result_valid_o(result_valid_o), .result_o(result_o),
        .result_idx_o(result_idx_o), .convert_start_select_o(cs), .sclk_o(sclk),
        .din_o(din), .dout_i(dout));
    adcscr_dev_model i_dev (.cs_i(cs), .sclk_i(sclk), .din_i(din), .dout_o(dout),
        .sample_i(res_v), .cfg_o(dev_cfg), .act_o(dev_act));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic cmp_res(input logic [17:0] got, input logic [17:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected result at %0t: %h vs %h", $time, got, exp);
        end
    endtask
    task automatic cmp_cfg(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected config at %0t: %h vs %h", $time, got, exp);
        end
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // one request, then a bounded wait for idle
    task automatic req(input logic cfg, input logic [7:0] b);
        int i;
        @(negedge clk_sys_i);
        cfg_byte_i = b;
        cfg_req_i  = cfg;
        conv_req_i = !cfg;
        @(negedge clk_sys_i);
        cfg_req_i  = 1'h0;
        conv_req_i = 1'h0;
        for (i = 0; i < 3000 && busy_o !== 1'h0; i++) @(negedge clk_sys_i);
        if (i == 3000) begin
            n_fail++;
            final_report();
        end
    endtask
    task automatic conv();
        res_v = 18'(rnd());
        exp_q.push_back(res_v);
        req(1'h0, 8'(rnd()));
    endtask
    // every word out matches the oldest queued sample
    always @(negedge clk_sys_i) begin
        if (result_valid_o === 1'h1) begin
            cmp_res(result_o, exp_q.pop_front());
            cmp_res({16'h0, result_idx_o}, 18'h0);
        end
    end
    initial begin
        repeat (3) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        rst_i = 1'h0;
        // every output mode, random reference and reserved bits, then shutdown
        for (int m = 0; m < 5; m++) begin
            logic [7:0] b;
            b = 8'(rnd());
            if (m < 4) b[7:6] = m[1:0];
            b[3] = (m == 4);
            req(1'h1, b);
            cmp_cfg(dev_cfg, b[3] ? 8'h00 : b & 8'hf8);
            cmp_cfg(dev_act, exp_act);
            conv();
            conv();
            exp_act = b[3] ? 8'h00 : b & 8'hf8;
            cmp_cfg(dev_act, exp_act);
        end
        repeat (4) @(negedge clk_sys_i);
        cmp_res(18'(exp_q.size()), 18'h0);
        final_report();
    end
    initial begin
        #100000;
        n_fail++;
        final_report();
    end
endmodule // tb
